// ==== core/ctc_pkg.sv ====
// What this block does
// - Hysteresis bit ignored in fixed threshold mode
// - Average settles with time constant 2^(field+1)
// - Configuration register layout, preset 0x19
// - Fixed mode compares data to threshold value
// - Adaptive mode compares data to running average
// - Mode 00 active when data below limit
// - Modes 01/10/11: above, in-window, out-window
// - Conversion mode 000 idle, 001 continuous, alternating when both channels enabled
package ctc_pkg;
  localparam logic [7:0] ADDR_SETUP_CH1 = 8'h0b;
  localparam logic [7:0] ADDR_SETUP_CH2 = 8'h0e;
  localparam logic [7:0] ADDR_CONFIG = 8'h0f;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] CONFIG_RESET = 8'h19;
  localparam logic [7:0] SETUP_RESET = 8'h0b;
  // Configuration fields
  localparam int CFG_THR_FIXED = 7;
  localparam int CFG_MODE_HI = 6;
  localparam int CFG_MODE_LO = 5;
  localparam int CFG_EN_CH1 = 4;
  localparam int CFG_EN_CH2 = 3;
  localparam int CFG_CONV_MSB = 2;
  // Setup fields
  localparam int SETUP_HYST = 4;
  localparam int SETUP_SETTLE_MSB = 3;
  localparam int SETTLE_W = 4;
  // Hysteresis margin is sensitivity shifted right by this amount
  localparam int HYST_SHIFT = 2;
  localparam logic [2:0] CONV_IDLE = 3'h0;
  localparam logic [2:0] CONV_CONTINUOUS = 3'h1;
  localparam logic [1:0] CMP_NEGATIVE = 2'h0;
  localparam logic [1:0] CMP_POSITIVE = 2'h1;
  localparam logic [1:0] CMP_IN_WINDOW = 2'h2;
  localparam logic [1:0] CMP_OUT_WINDOW = 2'h3;
  typedef enum logic [1:0] {
    CTC_SEQ_IDLE,
    CTC_SEQ_REQ,
    CTC_SEQ_WAIT
  } ctc_seq_e;
endpackage

// ==== core/ctc_average.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_average #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // New result
  input wire logic sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic [ctc_pkg::SETTLE_W-1:0] settle,
  // Average
  output logic [DATA_W-1:0] average
);
  // Sixteen fraction bits so even the slowest time constant still moves
  localparam int FRAC_W = 16;
  localparam int ACC_W = DATA_W + FRAC_W;

  initial begin
    if (DATA_W < 2 || DATA_W > 32) begin
      $error("ctc_average: DATA_W out of range");
    end
  end

  logic [ACC_W-1:0] acc;
  logic primed;
  logic signed [ACC_W:0] diff;
  logic signed [ACC_W:0] step;
  logic [ACC_W-1:0] next_acc;

  always_comb begin
    diff = $signed({1'b0, sample_data, {FRAC_W{1'b0}}})
         - $signed({1'b0, acc});
    step = diff >>> ({1'b0, settle} + 5'h01);
    next_acc = ACC_W'($signed({1'b0, acc}) + step);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      primed <= 1'b0;
    end else if (ce && sample_valid) begin
      primed <= 1'b1;
      if (primed) begin
        acc <= next_acc;
      end else begin
        acc <= {sample_data, {FRAC_W{1'b0}}};
      end
    end
  end

  assign average = acc[ACC_W-1:FRAC_W];
endmodule
`default_nettype wire

// ==== core/ctc_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_core #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Converter control
  output logic conv_request,
  output logic conv_channel,
  input wire logic result_valid,
  input wire logic result_channel,
  input wire logic [DATA_W-1:0] result_data,
  // Per-channel limits
  input wire logic [DATA_W-1:0] sensitivity_ch1,
  input wire logic [DATA_W-1:0] sensitivity_ch2,
  input wire logic [DATA_W-1:0] threshold_ch1,
  input wire logic [DATA_W-1:0] threshold_ch2,
  // Detection outputs
  output logic detect_ch1,
  output logic detect_ch2,
  output logic [DATA_W-1:0] average_ch1,
  output logic [DATA_W-1:0] average_ch2
);
  localparam int EW = DATA_W + 2;

  initial begin
    if (DATA_W < 2 || DATA_W > 32) begin
      $error("ctc_core: DATA_W out of range");
    end
  end

  logic [7:0] detection_configuration;
  logic [7:0] setup_ch1;
  logic [7:0] setup_ch2;
  ctc_pkg::ctc_seq_e seq;
  logic last_channel;

  wire logic thr_fixed = detection_configuration[ctc_pkg::CFG_THR_FIXED];
  wire logic [1:0] cmp_mode =
    detection_configuration[ctc_pkg::CFG_MODE_HI:ctc_pkg::CFG_MODE_LO];
  wire logic en_ch1 = detection_configuration[ctc_pkg::CFG_EN_CH1];
  wire logic en_ch2 = detection_configuration[ctc_pkg::CFG_EN_CH2];
  wire logic [2:0] conv_mode =
    detection_configuration[ctc_pkg::CFG_CONV_MSB:0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detection_configuration <= ctc_pkg::CONFIG_RESET;
      setup_ch1 <= ctc_pkg::SETUP_RESET;
      setup_ch2 <= ctc_pkg::SETUP_RESET;
    end else if (ce && reg_wr) begin
      if (reg_addr == ctc_pkg::ADDR_CONFIG) begin
        detection_configuration <= reg_wdata;
      end else if (reg_addr == ctc_pkg::ADDR_SETUP_CH1) begin
        setup_ch1 <= reg_wdata;
      end else if (reg_addr == ctc_pkg::ADDR_SETUP_CH2) begin
        setup_ch2 <= reg_wdata;
      end
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (ce && reg_rd) begin
      if (reg_addr == ctc_pkg::ADDR_CONFIG) begin
        reg_rdata <= detection_configuration;
      end else if (reg_addr == ctc_pkg::ADDR_SETUP_CH1) begin
        reg_rdata <= setup_ch1;
      end else if (reg_addr == ctc_pkg::ADDR_SETUP_CH2) begin
        reg_rdata <= setup_ch2;
      end else if (reg_addr == ctc_pkg::ADDR_STATUS) begin
        reg_rdata <= {5'h0_0, conv_request, detect_ch2, detect_ch1};
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // Choose next channel; alternate when both are enabled
  function automatic logic pick_channel(input logic last, input logic e1,
                                        input logic e2);
    if (e1 && e2) begin
      pick_channel = ~last;
    end else begin
      pick_channel = e2 && !e1;
    end
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq <= ctc_pkg::CTC_SEQ_IDLE;
      conv_channel <= 1'b0;
      last_channel <= 1'b1;
    end else if (ce) begin
      case (seq)
        ctc_pkg::CTC_SEQ_IDLE: begin
          if (conv_mode == ctc_pkg::CONV_CONTINUOUS &&
              (en_ch1 || en_ch2)) begin
            conv_channel <= pick_channel(last_channel, en_ch1, en_ch2);
            seq <= ctc_pkg::CTC_SEQ_REQ;
          end
        end
        ctc_pkg::CTC_SEQ_REQ: begin
          seq <= ctc_pkg::CTC_SEQ_WAIT;
        end
        ctc_pkg::CTC_SEQ_WAIT: begin
          if (result_valid) begin
            last_channel <= conv_channel;
            seq <= ctc_pkg::CTC_SEQ_IDLE;
          end
        end
        default: begin
          seq <= ctc_pkg::CTC_SEQ_IDLE;
        end
      endcase
    end
  end

  assign conv_request = (seq == ctc_pkg::CTC_SEQ_REQ);

  wire logic valid_ch1 = result_valid && !result_channel;
  wire logic valid_ch2 = result_valid && result_channel;

  ctc_average #(
    .DATA_W(DATA_W)
  ) u_avg_ch1 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sample_valid(valid_ch1),
    .sample_data(result_data),
    .settle(setup_ch1[ctc_pkg::SETUP_SETTLE_MSB:0]),
    .average(average_ch1)
  );

  ctc_average #(
    .DATA_W(DATA_W)
  ) u_avg_ch2 (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .sample_valid(valid_ch2),
    .sample_data(result_data),
    .settle(setup_ch2[ctc_pkg::SETUP_SETTLE_MSB:0]),
    .average(average_ch2)
  );

  function automatic logic signed [EW-1:0] ext(input logic [DATA_W-1:0] v);
    ext = $signed({2'b00, v});
  endfunction

  // Decide detection for one channel from its latest result
  function automatic logic detect_eval(
    input logic fixed, input logic [1:0] mode, input logic hyst,
    input logic active, input logic [DATA_W-1:0] data,
    input logic [DATA_W-1:0] avg, input logic [DATA_W-1:0] sens,
    input logic [DATA_W-1:0] thr);
    logic signed [EW-1:0] d;
    logic signed [EW-1:0] lo;
    logic signed [EW-1:0] hi;
    logic signed [EW-1:0] m;
    d = ext(data);
    lo = '0;
    hi = '0;
    m = '0;
    if (fixed) begin
      lo = ext(thr);
      hi = ext(thr);
    end else begin
      lo = ext(avg) - ext(sens);
      hi = ext(avg) + ext(sens);
      if (hyst && active) begin
        m = ext(sens) >>> ctc_pkg::HYST_SHIFT;
      end
    end
    case (mode)
      ctc_pkg::CMP_NEGATIVE: detect_eval = d < lo + m;
      ctc_pkg::CMP_POSITIVE: detect_eval = d > hi - m;
      ctc_pkg::CMP_IN_WINDOW: detect_eval = (d > lo - m) && (d < hi + m);
      default: detect_eval = (d < lo + m) || (d > hi - m);
    endcase
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      detect_ch1 <= 1'b0;
      detect_ch2 <= 1'b0;
    end else if (ce) begin
      if (valid_ch1) begin
        detect_ch1 <= detect_eval(thr_fixed, cmp_mode,
          setup_ch1[ctc_pkg::SETUP_HYST], detect_ch1, result_data,
          average_ch1, sensitivity_ch1, threshold_ch1);
      end
      if (valid_ch2) begin
        detect_ch2 <= detect_eval(thr_fixed, cmp_mode,
          setup_ch2[ctc_pkg::SETUP_HYST], detect_ch2, result_data,
          average_ch2, sensitivity_ch2, threshold_ch2);
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ctc_conv_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_conv_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request side
  input wire logic conv_request,
  input wire logic conv_channel,
  input wire logic slow,
  input wire logic [15:0] data_ch1,
  // Result side
  output logic result_valid,
  output logic result_channel,
  output logic [15:0] result_data
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      result_valid <= 1'b0;
      result_channel <= 1'b0;
      result_data <= 16'h0000;
    end else begin
      result_valid <= cnt == 1;
      // Data is only meaningful with the valid pulse
      result_data <= ~result_data;
      if (conv_request) begin
        cnt <= slow ? 40 : 3;
        result_channel <= conv_channel;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
      if (cnt == 1) begin
        result_data <= result_channel ? ~data_ch1 : data_ch1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ctc_core_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module ctc_core_asserts #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Observed ports
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic conv_request,
  input wire logic conv_channel,
  input wire logic result_valid,
  input wire logic result_channel,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic detect_ch1,
  input wire logic detect_ch2,
  input wire logic [DATA_W-1:0] average_ch1,
  input wire logic [DATA_W-1:0] average_ch2
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic r1;
  logic r2;
  assign r1 = ce && result_valid && !result_channel;
  assign r2 = ce && result_valid && result_channel;
  sequence s_req_start;
    !conv_request ##1 (conv_request && ce);
  endsequence
  AST_REQ_PULSE: assert property (s_req_start |=> !conv_request)
    else $error("request wider than one cycle");
  AST_CHAN_HOLD: assert property (!conv_request |-> $stable(conv_channel))
    else $error("channel moved without request");
  AST_DET1_HOLD: assert property (!r1 |=> $stable(detect_ch1))
    else $error("detect one moved without result");
  AST_DET2_HOLD: assert property (!r2 |=> $stable(detect_ch2))
    else $error("detect two moved without result");
  AST_AVG1_HOLD: assert property (!r1 |=> $stable(average_ch1))
    else $error("average one moved without result");
  AST_AVG2_HOLD: assert property (!r2 |=> $stable(average_ch2))
    else $error("average two moved without result");
  AST_AVG_KEEP: assert property (r1 && result_data == average_ch1 |=>
    average_ch1 == $past(result_data))
    else $error("settled average drifted");
  AST_RD_HOLD: assert property (!(ce && reg_rd) |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0;
  logic rst_n = 0;
  logic ce = 1;
  logic slow = 0;
  logic reg_wr = 0;
  logic reg_rd = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic conv_request, conv_channel, result_valid, result_channel;
  logic detect_ch1, detect_ch2;
  logic [15:0] result_data, average_ch1, average_ch2;
  logic [15:0] data_ch1 = 16'h03e8;
  logic [15:0] sens = 16'h000a;
  logic [15:0] thr = 16'h0064;
  logic [3:0] chs = 4'h0;
  int nreq = 0;
  int n_mismatch = 0;
  int checks = 0;
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (rst_n && conv_request) begin
    nreq++;
    chs = {chs[2:0], conv_channel};
  end
  ctc_core i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_request(conv_request),
    .conv_channel(conv_channel), .result_valid(result_valid),
    .result_channel(result_channel), .result_data(result_data),
    .sensitivity_ch1(sens), .sensitivity_ch2(sens),
    .threshold_ch1(thr), .threshold_ch2(thr), .detect_ch1(detect_ch1),
    .detect_ch2(detect_ch2), .average_ch1(average_ch1),
    .average_ch2(average_ch2));
  ctc_conv_model i_conv (.clk(clk), .rst_n(rst_n),
    .conv_request(conv_request), .conv_channel(conv_channel), .slow(slow),
    .data_ch1(data_ch1), .result_valid(result_valid),
    .result_channel(result_channel), .result_data(result_data));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(negedge clk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 0;
    check("rdata", reg_rdata, exp);
  endtask
  // Counts results of one channel; the bound catches a stuck sequencer
  task automatic wait_res(int n, logic ch);
    int k;
    k = 0;
    while (n > 0) begin
      @(negedge clk);
      if (result_valid && result_channel == ch) n--;
      k++;
      if (k > 2000) begin
        check("timeout", 1, 0);
        give_verdict();
      end
    end
    @(negedge clk);
  endtask
  task automatic run(logic [7:0] cfg, logic [15:0] d, logic e);
    wr(8'h0f, cfg);
    data_ch1 = d;
    wait_res(2, 1'b0);
    check("detect", detect_ch1, e);
  endtask
  task automatic t_reset();
    rd(8'h0f, 8'h19);
    rd(8'h0b, 8'h0b);
    rd(8'h20, 8'h00);
    wait_res(2, 1'b0);
    check("alternate", chs[0] ^ chs[1], 1);
    check("avg2", average_ch2, 16'hfc17);
    check("detect2", detect_ch2, 0);
  endtask
  task automatic t_adaptive();
    slow = 1;
    wr(8'h0b, 8'h00);
    run(8'h11, 16'h03e8, 0);
    run(8'h51, 16'h03e8, 1);
    check("avg", average_ch1, 16'h03e8);
    run(8'h11, 16'h0384, 1);
    check("avg", average_ch1, 16'h039d);
    run(8'h71, 16'h0384, 1);
    run(8'h31, 16'h0384, 0);
    slow = 0;
  endtask
  // Hysteresis on: a fixed compare must not widen
  task automatic t_fixed();
    logic [7:0] exp;
    exp = 8'ha9;
    wr(8'h0b, 8'h10);
    for (int i = 0; i < 8; i++) begin
      run({1'b1, 2'(i), 5'h11}, i < 4 ? 16'h0032 : 16'h0065, exp[i]);
    end
  endtask
  // Second channel on a faster settling field; first channel stays apart
  task automatic t_chan2();
    wr(8'h0e, 8'h01);
    rd(8'h0e, 8'h01);
    data_ch1 = 16'h0400;
    wr(8'h0f, 8'h19);
    wait_res(2, 1'b1);
    check("detect2", detect_ch2, 1);
    check("avg2", average_ch2, 16'hfc0c);
    check("detect", detect_ch1, 0);
  endtask
  // Fixed out-window keeps both detects high whatever result lands last
  task automatic t_idle();
    int n0;
    wr(8'h0f, 8'hf9);
    wait_res(1, 1'b0);
    wait_res(1, 1'b1);
    wr(8'h0f, 8'hf0);
    repeat (60) @(negedge clk);
    n0 = nreq;
    repeat (80) @(negedge clk);
    check("requests", 16'(nreq - n0), 0);
    rd(8'h10, 8'h03);
    // Frozen by clock enable: the write must not land
    ce = 0;
    wr(8'h0f, 8'h19);
    ce = 1;
    rd(8'h0f, 8'hf0);
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    check("detect", detect_ch1, 0);
    rd(8'h0f, 8'h19);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_adaptive();
    t_fixed();
    t_chan2();
    t_idle();
    give_verdict();
  end
endmodule
bind ctc_core ctc_core_asserts #(.DATA_W(DATA_W)) i_chk (.clk(clk),
  .rst_n(rst_n), .ce(ce), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_request(conv_request), .conv_channel(conv_channel),
  .result_valid(result_valid), .result_channel(result_channel),
  .result_data(result_data), .detect_ch1(detect_ch1),
  .detect_ch2(detect_ch2), .average_ch1(average_ch1),
  .average_ch2(average_ch2));
`default_nettype wire
